/* File: hw/sbg_cfg.svh */
// Offsets, field positions, reset values and counts of the bit-rate generator
`ifndef SBG_CFG_SVH
`define SBG_CFG_SVH

`define SBG_OFF_TXCS       8'h00
`define SBG_OFF_RXCS       8'h04
`define SBG_OFF_RATEC      8'h08
`define SBG_OFF_DIVH       8'h0c
`define SBG_OFF_DIVL       8'h10
`define SBG_OFF_STATUS     8'h14

`define SBG_TXCS_SYNC_BIT  4
`define SBG_TXCS_HS_BIT    2
`define SBG_RXCS_EN_BIT    7
`define SBG_RATEC_WIDE_BIT 3
`define SBG_RATEC_WMASK    8'hfb

`define SBG_RST_BYTE       8'h00

`define SBG_RESP_OKAY      2'b00
`define SBG_RESP_SLVERR    2'b10

`define SBG_LAST_X64       6'h3f
`define SBG_LAST_X16       6'h0f
`define SBG_LAST_X4        6'h03
`define SBG_MID_X64        6'h20
`define SBG_MID_X16        6'h08
`define SBG_MID_X4         6'h02

`endif

/* File: hw/sbg_divider.sv */
// Free-running divider and prescaler that mark bit ticks and sample points
`timescale 1ns/1ps
`include "sbg_cfg.svh"
module sbg_divider
  import sbg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        enable,
  input  wire logic        clear,
  input  wire logic [15:0] divisor,
  input  wire sbg_mode_t   mode,
  input  wire logic        majority_en,
  output logic             bit_tick,
  output logic             sample_pt,
  output logic             sample_last
);

  sbg_div_state_t r;
  sbg_div_state_t n;
  logic [5:0]     last;
  logic [5:0]     mid;
  logic           base_wrap;

  always_comb begin
    n = r;
    n.bit_tick    = 1'b0;
    n.sample_pt   = 1'b0;
    n.sample_last = 1'b0;
    case (mode)
      SBG_MODE_X64: begin
        last = `SBG_LAST_X64;
        mid  = `SBG_MID_X64;
      end
      SBG_MODE_X16: begin
        last = `SBG_LAST_X16;
        mid  = `SBG_MID_X16;
      end
      default: begin
        last = `SBG_LAST_X4;
        mid  = `SBG_MID_X4;
      end
    endcase
    // Counts device clock cycles, so a slower clock slows the rate too
    // A zero divisor would give n+1 = 1, unsupported by the bit framing
    // Compare with >= so a smaller divisor or shorter prescale wraps at once
    // instead of running the counters round their full width
    base_wrap = (r.base_cnt >= divisor);
    if (base_wrap) begin
      n.base_cnt = 16'h0000;
      n.pre_cnt  = (r.pre_cnt >= last) ? 6'h00 : r.pre_cnt + 6'h01;
      n.bit_tick = (r.pre_cnt >= last);
      if (majority_en) begin
        n.sample_pt   = (r.pre_cnt == mid - 6'h01) || (r.pre_cnt == mid)
                        || (r.pre_cnt == mid + 6'h01);
        n.sample_last = (r.pre_cnt == mid + 6'h01);
      end else begin
        n.sample_pt   = (r.pre_cnt == mid);
        n.sample_last = (r.pre_cnt == mid);
      end
    end else begin
      n.base_cnt = r.base_cnt + 16'h0001;
    end
    // A new divisor restarts the count rather than waiting for a wrap
    if (!aresetn || !enable || clear) begin
      n = '0;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end

  assign bit_tick    = r.bit_tick;
  assign sample_pt   = r.sample_pt;
  assign sample_last = r.sample_last;

endmodule : sbg_divider

/* File: hw/sbg_pkg.sv */
// Types shared by the bit-rate generator modules
package sbg_pkg;

  typedef enum logic [1:0] {
    SBG_MODE_X64 = 2'b00,
    SBG_MODE_X16 = 2'b01,
    SBG_MODE_X4  = 2'b10
  } sbg_mode_t;

  typedef struct packed {
    logic [15:0] base_cnt;
    logic [5:0]  pre_cnt;
    logic        bit_tick;
    logic        sample_pt;
    logic        sample_last;
  } sbg_div_state_t;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       sync3;
    logic       level;
    logic [1:0] votes;
    logic [1:0] taken;
    logic       rx_level;
    logic       rx_strobe;
  } sbg_smp_state_t;

  typedef struct packed {
    logic [7:0]  txcs;
    logic [7:0]  rxcs;
    logic [7:0]  ratec;
    logic [7:0]  divh;
    logic [7:0]  divl;
    logic        div_clear;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sbg_regs_t;

endpackage : sbg_pkg

/* File: hw/sbg_rx_sampler.sv */
// Receive pin synchroniser with majority-of-three or single sampling
`timescale 1ns/1ps
module sbg_rx_sampler
  import sbg_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic rx_pin,
  input  wire logic sample_pt,
  input  wire logic sample_last,
  input  wire logic majority_en,
  output logic      rx_level,
  output logic      rx_strobe
);

  sbg_smp_state_t r;
  sbg_smp_state_t n;

  always_comb begin
    n = r;
    n.rx_strobe = 1'b0;
    n.sync1 = rx_pin;
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;
    // Pin change counts only when the last two stages agree
    if (r.sync2 == r.sync3) begin
      n.level = r.sync3;
    end
    if (sample_pt) begin
      n.votes = r.votes + {1'b0, r.level};
      n.taken = r.taken + 2'b01;
      if (sample_last) begin
        n.votes     = 2'b00;
        n.taken     = 2'b00;
        n.rx_strobe = 1'b1;
        if (majority_en) begin
          n.rx_level = ((r.votes + {1'b0, r.level}) >= 2'b10);
        end else begin
          n.rx_level = r.level;
        end
      end
    end
    if (!aresetn) begin
      n = '0;
      n.rx_level = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end

  assign rx_level  = r.rx_level;
  assign rx_strobe = r.rx_strobe;

endmodule : sbg_rx_sampler

/* File: hw/sbg_top.sv */
// Bit-rate generator with receive sampling and its AXI4-Lite register file
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sbg_cfg.svh"
module sbg_top
  import sbg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_pin,
  output logic             rate_tick,
  output logic             rx_level,
  output logic             rx_strobe
);

  sbg_regs_t   r;
  sbg_regs_t   n;
  logic        sync_mode;
  logic        high_speed_select;
  logic        wide_divider_select;
  logic        port_enable;
  logic        majority_en;
  sbg_mode_t   mode;
  logic [15:0] divisor;
  logic        sample_pt;
  logic        sample_last;
  logic [7:0]  waddr;
  logic [7:0]  raddr;

  assign sync_mode           = r.txcs[`SBG_TXCS_SYNC_BIT];
  assign high_speed_select   = r.txcs[`SBG_TXCS_HS_BIT];
  assign wide_divider_select = r.ratec[`SBG_RATEC_WIDE_BIT];
  assign port_enable         = r.rxcs[`SBG_RXCS_EN_BIT];

  // Vote only where a bit spans enough prescaler steps for three samples
  assign majority_en = !sync_mode && !(wide_divider_select && high_speed_select);

  always_comb begin
    if (sync_mode) begin
      mode = SBG_MODE_X4;
    end else if (wide_divider_select && high_speed_select) begin
      mode = SBG_MODE_X4;
    end else if (wide_divider_select || high_speed_select) begin
      mode = SBG_MODE_X16;
    end else begin
      mode = SBG_MODE_X64;
    end
  end

  // High byte is ignored until the wide divider is selected
  assign divisor = wide_divider_select ? {r.divh, r.divl} : {8'h00, r.divl};

  sbg_divider u_divider (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .enable      (port_enable),
    .clear       (r.div_clear),
    .divisor     (divisor),
    .mode        (mode),
    .majority_en (majority_en),
    .bit_tick    (rate_tick),
    .sample_pt   (sample_pt),
    .sample_last (sample_last)
  );

  sbg_rx_sampler u_sampler (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .rx_pin      (rx_pin),
    .sample_pt   (sample_pt),
    .sample_last (sample_last),
    .majority_en (majority_en),
    .rx_level    (rx_level),
    .rx_strobe   (rx_strobe)
  );

  function automatic logic [31:0] read_word(input sbg_regs_t s, input logic [7:0] a,
                                            input logic lvl, input logic maj);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `SBG_OFF_TXCS:   d = {24'h00_0000, s.txcs};
      `SBG_OFF_RXCS:   d = {24'h00_0000, s.rxcs};
      `SBG_OFF_RATEC:  d = {24'h00_0000, s.ratec};
      `SBG_OFF_DIVH:   d = {24'h00_0000, s.divh};
      `SBG_OFF_DIVL:   d = {24'h00_0000, s.divl};
      `SBG_OFF_STATUS: d = {30'h0000_0000, maj, lvl};
      default:         d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_word

  function automatic logic mapped(input logic [7:0] a);
    logic m;
    m = (a == `SBG_OFF_TXCS) || (a == `SBG_OFF_RXCS) || (a == `SBG_OFF_RATEC)
        || (a == `SBG_OFF_DIVH) || (a == `SBG_OFF_DIVL) || (a == `SBG_OFF_STATUS);
    return m;
  endfunction : mapped

  assign waddr = {r.aw_addr[7:2], 2'b00};
  assign raddr = {s_axi_araddr[7:2], 2'b00};

  always_comb begin
    n = r;
    n.div_clear = 1'b0;
    if (r.awready && s_axi_awvalid) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (r.wready && s_axi_wvalid) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_have && r.w_have && !r.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = mapped(waddr) ? `SBG_RESP_OKAY : `SBG_RESP_SLVERR;
      if (r.wstrb0) begin
        case (waddr)
          `SBG_OFF_TXCS:  n.txcs  = r.wdata;
          `SBG_OFF_RXCS:  n.rxcs  = r.wdata;
          `SBG_OFF_RATEC: n.ratec = r.wdata & `SBG_RATEC_WMASK;
          `SBG_OFF_DIVH: begin
            n.divh      = r.wdata;
            n.div_clear = 1'b1;
          end
          `SBG_OFF_DIVL: begin
            n.divl      = r.wdata;
            n.div_clear = 1'b1;
          end
          default: n.div_clear = 1'b0;
        endcase
      end
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (r.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rdata  = read_word(r, raddr, rx_level, majority_en);
      n.rresp  = mapped(raddr) ? `SBG_RESP_OKAY : `SBG_RESP_SLVERR;
    end
    // One write and one read in flight keeps the slave free of queues
    n.awready = !n.aw_have && !n.bvalid;
    n.wready  = !n.w_have && !n.bvalid;
    n.arready = !n.rvalid;
    if (!aresetn) begin
      n = '0;
      n.txcs  = `SBG_RST_BYTE;
      n.rxcs  = `SBG_RST_BYTE;
      n.ratec = `SBG_RST_BYTE;
      n.divh  = `SBG_RST_BYTE;
      n.divl  = `SBG_RST_BYTE;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;

endmodule : sbg_top

/* File: verification/sbg_line_model.sv */
// Remote transmitter model driving the receive pin
`timescale 1ns/1ps
module sbg_line_model (
  input  wire logic aclk,
  output logic      rx_pin
);
  initial rx_pin = 1'b1;
  // Start low, data LSB first, stop high; the line idles high
  task automatic send(input logic [7:0] b, input int clks);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin <= f[i];
      repeat (clks) @(posedge aclk);
    end
  endtask : send
  // Single-cycle dips: noise that the synchroniser's last-two-stages agreement must reject
  task automatic glitch(input int k);
    repeat (k) begin
      rx_pin <= 1'b0;
      @(posedge aclk);
      rx_pin <= 1'b1;
      repeat (4) @(posedge aclk);
    end
  endtask : glitch
endmodule : sbg_line_model

/* File: verification/sbg_sva.sv */
// Port checker for the bit-rate generator
`timescale 1ns/1ps
module sbg_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rate_tick,
  input wire logic        rx_level,
  input wire logic        rx_strobe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Nonzero divisor and a prescale of at least 4 keep ticks 8 cycles apart
  a_tick_gap: assert property (rate_tick |=> !rate_tick [*7])
    else $error("rate ticks too close");
  a_strobe_gap: assert property (rx_strobe |=> !rx_strobe [*7])
    else $error("receive decisions too close");
  a_level_hold: assert property (!$stable(rx_level) |-> rx_strobe)
    else $error("receive level moved without a decision");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready)
    else $error("read response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
endmodule : sbg_sva

/* File: verification/testbench.sv */
// Register-level bench for the bit-rate generator
`timescale 1ns/1ps
module testbench;
  import sbg_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, rate_tick, rx_level, rx_strobe, rx_pin;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  int failures = 0, n_checks = 0, cyc = 0, n, m = 0;
  logic [7:0] tx[6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h10, 8'h14};
  logic [7:0] rc[6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
  logic [7:0] st[6] = '{8'h03, 8'h03, 8'h03, 8'h01, 8'h01, 8'h01};
  int ex[6] = '{192, 48, 4144, 1036, 12, 1036};
  always #2 aclk = ~aclk;
  sbg_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_pin, .rate_tick, .rx_level, .rx_strobe);
  sbg_line_model u_line (.aclk, .rx_pin);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end while (s_axi_bready);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, d});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end while (s_axi_rready);
  endtask : rd
  // First tick after a mode change may be partial, so skip two
  task automatic period(input int exp);
    repeat (2) @(posedge aclk iff rate_tick);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rate_tick);
    chk(n, exp);
  endtask : period
  task automatic final_report;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 20; a += 4) rd(a[7:0], 8'h00, 2'b00);
    rd(8'h14, 8'h03, 2'b00);
    rd(8'h18, 8'h00, 2'b10);
    wr(8'h18, 8'h55, 2'b10);
    wr(8'h08, 8'hff, 2'b00);
    rd(8'h08, 8'hfb, 2'b00);
    wr(8'h0c, 8'h01, 2'b00);
    wr(8'h10, 8'h02, 2'b00);
    wr(8'h04, 8'h80, 2'b00);
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, tx[i], 2'b00);
      wr(8'h08, rc[i], 2'b00);
      rd(8'h14, st[i], 2'b00);
      period(ex[i]);
    end
    // Slow rate, then a fast reload mid-count must not wait out the old count
    wr(8'h00, 8'h04, 2'b00);
    wr(8'h08, 8'h00, 2'b00);
    wr(8'h10, 8'hff, 2'b00);
    @(posedge aclk iff rate_tick);
    repeat (200) @(posedge aclk);
    wr(8'h10, 8'h02, 2'b00);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rate_tick && n < 5000);
    chk(n <= 56, 1'b1);
    n = 0;
    fork
      u_line.glitch(40);
      repeat (200) begin
        @(posedge aclk);
        if (rx_level !== 1'b1) n++;
      end
    join
    chk(n, 0);
    n = 0;
    fork
      u_line.send(8'h00, 48);
      repeat (480) begin
        @(posedge aclk);
        if (rx_level === 1'b0) n++;
        if (rx_strobe === 1'b1) m++;
      end
    join
    chk(n > 0, 1'b1);
    chk(m, 10);
    repeat (150) @(posedge aclk);
    chk(rx_level, 1'b1);
    final_report();
  end
endmodule : testbench
bind sbg_top sbg_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .rate_tick, .rx_level, .rx_strobe);
